// >>> msr_regs.vh
// Purpose: offsets, field positions and reset values of the monitor status registers
// Assumes: 8-bit registers on the management bus address space
// Notes:   definitions only
`ifndef MSR_REGS_VH
`define MSR_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSR_ADDR_ANALOG_STATUS 8'h21
`define MSR_ADDR_FAN_STATUS    8'h22
`define MSR_ADDR_MISC_STATUS   8'h23

// ----------------------------------------------------------------
// misc_event_status bit positions
// ----------------------------------------------------------------
`define MSR_BIT_INT_TEMP   0
`define MSR_BIT_BATTERY    1
`define MSR_BIT_ANALOG8    2
`define MSR_BIT_THERMAL    3
`define MSR_BIT_AUTO_FAN   4
`define MSR_BIT_UNUSED     5
`define MSR_BIT_INTRUSION  6
`define MSR_BIT_GPIN16     7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSR_RESET_VALUE    8'h00

`endif

// >>> msr_status_regs.v
// Purpose: three status registers of a system hardware monitor
// Assumes: compare results and event pulses come from logic on the same clock
// Notes:   general pin and intrusion inputs are pins and are synchronised;
//          event bits 3, 4 and 6 clear when the register is read;
//          bit 7 reads the written value, before polarity, while the pin is an output;
//          limit bits are refreshed by each conversion, not sticky
//
// Functional notes
// - analog input bits show out-of-limit result of last conversion per channel
// - fan bits show only above-high-limit result of last conversion, no low check
// - bit 0 shows internal temperature out-of-limit from previous conversion
// - bit 0 also set once when thermal alarm engages on internal temperature
// - bit 0 also set once when thermal alarm disengages on internal temperature
// - bits 1 and 2 show battery and ninth analog input out-of-limit
// - bit 3 set once when thermal alarm engages on any channel
// - bit 3 set once when thermal alarm disengages on any channel
// - bit 4 set once when automatic fan control switches fan on
// - bit 4 set once when fan switches off in automatic fan control
// - bit 5 always reads zero
// - bit 6 latches chassis intrusion until cleared by a read
// - bit 7 reads 1 while general pin asserted, when pin is input
// - writing 1 to bit 7 asserts pin when configured as output
// - asserted level of the general pin follows its polarity setting
// - all three registers clear to 0x00 at reset, except misc bit 7, which reads 1 while the pin is an active-low input
// - bit 7 rejects writes unless the pin is configured as output
`timescale 1ns/1ps
`include "msr_regs.vh"
`default_nettype none

module msr_status_regs
#(
    parameter ANALOG_CHANNELS = 8,
    parameter FAN_CHANNELS    = 8
)
(
    // clock and reset
    input  wire                       clock,
    input  wire                       rst_b,
    // register access port
    input  wire [7:0]                 regAddr,
    input  wire                       regWrite,
    input  wire                       regRead,
    input  wire [7:0]                 regWrData,
    output reg  [7:0]                 regRdData,
    // per-channel compare results, valid with their done strobes
    input  wire [ANALOG_CHANNELS-1:0] analogDone,
    input  wire [ANALOG_CHANNELS-1:0] analogHigh,
    input  wire [ANALOG_CHANNELS-1:0] analogLow,
    input  wire [FAN_CHANNELS-1:0]    fanDone,
    input  wire [FAN_CHANNELS-1:0]    fanHigh,
    input  wire                       intTempDone,
    input  wire                       intTempOut,
    input  wire                       batteryDone,
    input  wire                       batteryOut,
    input  wire                       analogEightDone,
    input  wire                       analogEightOut,
    // one-cycle event pulses and the automatic fan mode level
    input  wire                       intThermalEngage,
    input  wire                       intThermalRelease,
    input  wire                       thermalEngage,
    input  wire                       thermalRelease,
    input  wire                       autoFanOn,
    input  wire                       autoFanOff,
    input  wire                       autoFanMode,
    // pins and pin configuration
    input  wire                       intrusionPin,
    input  wire                       pinSixteenIn,
    input  wire                       pinSixteenIsOutput,
    input  wire                       pinSixteenActiveHigh,
    output reg                        pinSixteenOut,
    output reg                        pinSixteenOe
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // the first stage may go metastable, so only the second stage is read
    // by any logic; this costs two cycles of latency on both pins
    reg [1:0] intrSync_q;
    reg [1:0] pinSync_q;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            intrSync_q <= 2'h0;
            pinSync_q  <= 2'h0;
        end
        else
        begin
            intrSync_q <= {intrSync_q[0], intrusionPin};
            pinSync_q  <= {pinSync_q[0], pinSixteenIn};
        end
    end

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    // limit bits follow each done strobe and are not sticky
    reg [ANALOG_CHANNELS-1:0] analogStat_q;
    reg [FAN_CHANNELS-1:0]    fanStat_q;
    reg                       intTemp_q;
    reg                       battery_q;
    reg                       analogEight_q;
    reg                       thermal_q;
    reg                       autoFan_q;
    reg                       intrusion_q;
    reg                       pinDrive_q;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // shared by the misc write strobe and the clear-on-read strobe; the read data mux decodes regAddr in its own case
    function addrHit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addrHit = (addr == target);
        end
    endfunction

    wire readMisc  = regRead && addrHit(regAddr, `MSR_ADDR_MISC_STATUS);
    wire writeMisc = regWrite && addrHit(regAddr, `MSR_ADDR_MISC_STATUS);

    // asserted level of the pin, after polarity
    wire pinAsserted = pinSixteenActiveHigh ? pinSync_q[1] : ~pinSync_q[1];

    // ----------------------------------------------------------------
    // per-channel limit bits
    // ----------------------------------------------------------------
    // one flop per channel, so a strobe on one channel leaves the others alone
    genvar gi;
    generate
        for (gi = 0; gi < ANALOG_CHANNELS; gi = gi + 1)
        begin : gAnalog
            always @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    analogStat_q[gi] <= 1'b0;
                else if (analogDone[gi])
                    analogStat_q[gi] <= analogHigh[gi] | analogLow[gi];
            end
        end
        for (gi = 0; gi < FAN_CHANNELS; gi = gi + 1)
        begin : gFan
            always @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    fanStat_q[gi] <= 1'b0;
                else if (fanDone[gi])
                    fanStat_q[gi] <= fanHigh[gi];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // misc register bits
    // ----------------------------------------------------------------
    // event bits are sticky until the register is read; an event in the
    // reading cycle wins so it is never lost
    reg                       intTemp_d;
    reg                       battery_d;
    reg                       analogEight_d;
    reg                       thermal_d;
    reg                       autoFan_d;
    reg                       intrusion_d;
    reg                       pinDrive_d;

    always @*
    begin
        intTemp_d     = intTemp_q;
        battery_d     = battery_q;
        analogEight_d = analogEight_q;
        thermal_d     = thermal_q;
        autoFan_d     = autoFan_q;
        intrusion_d   = intrusion_q;
        pinDrive_d    = pinDrive_q;
        // alarm events override a conversion result landing in the same cycle
        if (intThermalEngage || intThermalRelease)
            intTemp_d = 1'b1;
        else if (intTempDone)
            intTemp_d = intTempOut;
        if (batteryDone)
            battery_d = batteryOut;
        if (analogEightDone)
            analogEight_d = analogEightOut;
        if (thermalEngage || thermalRelease)
            thermal_d = 1'b1;
        else if (readMisc)
            thermal_d = 1'b0;
        // fan switching outside automatic mode is not reported
        if (autoFanMode && (autoFanOn || autoFanOff))
            autoFan_d = 1'b1;
        else if (readMisc)
            autoFan_d = 1'b0;
        // a read cannot clear the flag while the synchronised pin is still high
        if (intrSync_q[1])
            intrusion_d = 1'b1;
        else if (readMisc)
            intrusion_d = 1'b0;
        if (writeMisc && pinSixteenIsOutput)
            pinDrive_d = regWrData[`MSR_BIT_GPIN16];
    end

    // ----------------------------------------------------------------
    // misc register flops
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            intTemp_q     <= 1'b0;
            battery_q     <= 1'b0;
            analogEight_q <= 1'b0;
            thermal_q     <= 1'b0;
            autoFan_q     <= 1'b0;
            intrusion_q   <= 1'b0;
            pinDrive_q    <= 1'b0;
        end
        else
        begin
            intTemp_q     <= intTemp_d;
            battery_q     <= battery_d;
            analogEight_q <= analogEight_d;
            thermal_q     <= thermal_d;
            autoFan_q     <= autoFan_d;
            intrusion_q   <= intrusion_d;
            pinDrive_q    <= pinDrive_d;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // polarity is applied on the way out, so the stored bit always means asserted
    wire pinSixteenOut_d = pinSixteenActiveHigh ? pinDrive_q : ~pinDrive_q;

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinSixteenOut <= 1'b0;
            pinSixteenOe  <= 1'b0;
        end
        else
        begin
            pinSixteenOe  <= pinSixteenIsOutput;
            pinSixteenOut <= pinSixteenOut_d;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    reg [7:0] miscView;

    always @*
    begin
        miscView = `MSR_RESET_VALUE;
        miscView[`MSR_BIT_INT_TEMP]  = intTemp_q;
        miscView[`MSR_BIT_BATTERY]   = battery_q;
        miscView[`MSR_BIT_ANALOG8]   = analogEight_q;
        miscView[`MSR_BIT_THERMAL]   = thermal_q;
        miscView[`MSR_BIT_AUTO_FAN]  = autoFan_q;
        miscView[`MSR_BIT_UNUSED]    = 1'b0;
        miscView[`MSR_BIT_INTRUSION] = intrusion_q;
        miscView[`MSR_BIT_GPIN16]    = pinSixteenIsOutput ? pinDrive_q : pinAsserted;
    end

    reg [7:0] regRdData_d;

    // unmapped addresses read zero; data stands until the next read
    // sticky bits clear on the same edge that captures them, so none is lost
    always @*
    begin
        regRdData_d = regRdData;
        if (regRead)
        begin
            case (regAddr)
                `MSR_ADDR_ANALOG_STATUS: regRdData_d = analogStat_q[7:0];
                `MSR_ADDR_FAN_STATUS:    regRdData_d = fanStat_q[7:0];
                `MSR_ADDR_MISC_STATUS:   regRdData_d = miscView;
                default:                 regRdData_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read register
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            regRdData <= `MSR_RESET_VALUE;
        else
            regRdData <= regRdData_d;
    end

endmodule // msr_status_regs

`default_nettype wire

// >>> msr_host_model.sv
// Purpose: management bus host issuing single register reads and writes
// Assumes: tasks are entered just after a rising edge of clock
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module msr_host_model (
    // clock and read data
    input wire logic clock,
    input wire logic [7:0] regRdData,
    // request side
    output logic [7:0] regAddr = 8'h00,
    output logic regWrite = 1'b0,
    output logic regRead = 1'b0,
    output logic [7:0] regWrData = 8'h00
);
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clock);
        d = regRdData;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
        @(posedge clock);
    endtask
endmodule // msr_host_model
`default_nettype wire

// >>> msr_status_checker.sv
// Purpose: port checks of the monitor status registers
// Assumes: one clock domain
// Notes:   bound to every msr_status_regs
`timescale 1ns/1ps
`default_nettype none
module msr_status_checker #(parameter ANALOG_CHANNELS = 8, parameter FAN_CHANNELS = 8) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // status sources
    input wire logic [ANALOG_CHANNELS-1:0] analogDone,
    input wire logic [ANALOG_CHANNELS-1:0] analogHigh,
    input wire logic [ANALOG_CHANNELS-1:0] analogLow,
    input wire logic [FAN_CHANNELS-1:0] fanDone,
    input wire logic [FAN_CHANNELS-1:0] fanHigh,
    input wire logic thermalEngage,
    input wire logic thermalRelease,
    input wire logic autoFanOn,
    input wire logic autoFanOff,
    input wire logic autoFanMode,
    input wire logic intrusionPin,
    // general pin
    input wire logic pinSixteenIsOutput,
    input wire logic pinSixteenActiveHigh,
    input wire logic pinSixteenOut,
    input wire logic pinSixteenOe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire rdMisc = regRead && regAddr == 8'h23;
    wire wrMisc = regWrite && regAddr == 8'h23;
    a_unused_zero: assert property (rdMisc |=> !regRdData[5]) else $error("bit 5 set");
    a_analog_result: assert property (analogDone[0] ##1
        (regRead && regAddr == 8'h21 && !analogDone[0]) |=>
        regRdData[0] == ($past(analogHigh[0], 2) || $past(analogLow[0], 2)))
        else $error("analog bit");
    a_fan_high_only: assert property ((fanDone[1] && !fanHigh[1]) ##1
        (regRead && regAddr == 8'h22) |=> !regRdData[1]) else $error("fan bit");
    a_thermal_event: assert property ((thermalEngage || thermalRelease) ##1 rdMisc
        |=> regRdData[3]) else $error("thermal bit");
    a_fan_event: assert property (autoFanMode && (autoFanOn || autoFanOff) ##1 rdMisc
        |=> regRdData[4]) else $error("auto fan bit");
    a_intrusion_latch: assert property ((intrusionPin && !regRead)[*4] ##1
        (!intrusionPin && !regRead)[*4] ##1 rdMisc |=> regRdData[6])
        else $error("intrusion lost");
    a_pin_drive_on: assert property (pinSixteenIsOutput[*3] |-> pinSixteenOe)
        else $error("oe low");
    a_pin_drive_off: assert property ((!pinSixteenIsOutput)[*3] |-> !pinSixteenOe)
        else $error("oe high");
    a_pin_polarity: assert property ((wrMisc && pinSixteenIsOutput) ##1
        (!regWrite && pinSixteenIsOutput && $stable(pinSixteenActiveHigh)) |=>
        pinSixteenOut == ($past(regWrData[7], 2) ~^ $past(pinSixteenActiveHigh)))
        else $error("pin level");
    a_write_reject: assert property ((wrMisc && !pinSixteenIsOutput) ##1
        $stable(pinSixteenActiveHigh) |=> $stable(pinSixteenOut))
        else $error("write not rejected");
endmodule // msr_status_checker
bind msr_status_regs msr_status_checker #(.ANALOG_CHANNELS(ANALOG_CHANNELS), .FAN_CHANNELS(FAN_CHANNELS)) chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Purpose: directed bench for the monitor status registers
// Assumes: host model drives the register port
// Notes:   each read of 23h clears its event bits
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin badCount++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic clock = 0;
    logic rst_b = 0;
    logic [7:0] analogDone = 0, analogHigh = 0, analogLow = 0, fanDone = 0, fanHigh = 0;
    logic intTempDone = 0, intTempOut = 1, batteryDone = 0, batteryOut = 0;
    logic analogEightDone = 0, analogEightOut = 1, autoFanMode = 0, intrusionPin = 0;
    logic intThermalEngage = 0, intThermalRelease = 0, thermalEngage = 0, thermalRelease = 0;
    logic autoFanOn = 0, autoFanOff = 0, pinSixteenIn = 0, pinSixteenIsOutput = 0;
    logic pinSixteenActiveHigh = 1;
    wire [7:0] regAddr, regWrData, regRdData;
    wire regWrite, regRead, pinSixteenOut, pinSixteenOe;
    int badCount = 0, nCompared = 0;
    always #5 clock = ~clock;
    msr_host_model host (
        .clock     (clock),
        .regRdData (regRdData),
        .regAddr   (regAddr),
        .regWrite  (regWrite),
        .regRead   (regRead),
        .regWrData (regWrData)
    );
    msr_status_regs uut (
        .clock                (clock),
        .rst_b                (rst_b),
        .regAddr              (regAddr),
        .regWrite             (regWrite),
        .regRead              (regRead),
        .regWrData            (regWrData),
        .regRdData            (regRdData),
        .analogDone           (analogDone),
        .analogHigh           (analogHigh),
        .analogLow            (analogLow),
        .fanDone              (fanDone),
        .fanHigh              (fanHigh),
        .intTempDone          (intTempDone),
        .intTempOut           (intTempOut),
        .batteryDone          (batteryDone),
        .batteryOut           (batteryOut),
        .analogEightDone      (analogEightDone),
        .analogEightOut       (analogEightOut),
        .intThermalEngage     (intThermalEngage),
        .intThermalRelease    (intThermalRelease),
        .thermalEngage        (thermalEngage),
        .thermalRelease       (thermalRelease),
        .autoFanOn            (autoFanOn),
        .autoFanOff           (autoFanOff),
        .autoFanMode          (autoFanMode),
        .intrusionPin         (intrusionPin),
        .pinSixteenIn         (pinSixteenIn),
        .pinSixteenIsOutput   (pinSixteenIsOutput),
        .pinSixteenActiveHigh (pinSixteenActiveHigh),
        .pinSixteenOut        (pinSixteenOut),
        .pinSixteenOe         (pinSixteenOe)
    );
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask
    task conv;
        {analogDone, fanDone, intTempDone, batteryDone, analogEightDone} <= 19'h7ffff;
        @(posedge clock);
        {analogDone, fanDone, intTempDone, batteryDone, analogEightDone} <= 19'h00000;
    endtask
    task pulse(input logic [5:0] m);
        {autoFanOff, autoFanOn, thermalRelease, thermalEngage, intThermalRelease, intThermalEngage} <= m;
        @(posedge clock);
        {autoFanOff, autoFanOn, thermalRelease, thermalEngage, intThermalRelease, intThermalEngage} <= 6'h00;
    endtask
    task endOfTest;
        $display("compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #20000;
        badCount++;
        endOfTest;
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rst_b <= 1;
        @(posedge clock);
        for (int i = 0; i < 4; i++)
            chk(8'h21 + i[7:0], 8'h00);
        $display("reset test done");
        analogHigh <= 8'h0f;
        analogLow <= 8'h30;
        fanHigh <= 8'ha5;
        conv;
        chk(8'h21, 8'h3f);
        conv;
        chk(8'h22, 8'ha5);
        host.wr(8'h21, 8'hff);
        host.wr(8'h22, 8'h00);
        chk(8'h21, 8'h3f);
        chk(8'h22, 8'ha5);
        $display("limit test done");
        chk(8'h23, 8'h05);
        pulse(6'h20);
        chk(8'h23, 8'h05);
        autoFanMode <= 1;
        pulse(6'h14);
        chk(8'h23, 8'h1d);
        pulse(6'h28);
        chk(8'h23, 8'h1d);
        intrusionPin <= 1;
        repeat (4) @(posedge clock);
        intrusionPin <= 0;
        repeat (4) @(posedge clock);
        chk(8'h23, 8'h45);
        intTempOut <= 0;
        for (int i = 0; i < 2; i++)
        begin
            conv;
            chk(8'h23, 8'h04);
            pulse(6'h01 << i);
            chk(8'h23, 8'h05);
        end
        $display("event test done");
        pinSixteenIn <= 1;
        repeat (3) @(posedge clock);
        chk(8'h23, 8'h85);
        pinSixteenActiveHigh <= 0;
        repeat (3) @(posedge clock);
        chk(8'h23, 8'h05);
        host.wr(8'h23, 8'hff);
        chk(8'h23, 8'h05);
        `CHK(pinSixteenOe, 1'b0)
        pinSixteenIsOutput <= 1;
        for (int i = 0; i < 4; i++)
        begin
            pinSixteenActiveHigh <= i[1];
            host.wr(8'h23, i[0] ? 8'h00 : 8'h80);
            repeat (2) @(posedge clock);
            @(negedge clock);
            `CHK({pinSixteenOe, pinSixteenOut}, {1'b1, i[0] ^ i[1]})
            @(posedge clock);
            chk(8'h23, i[0] ? 8'h05 : 8'h85);
        end
        $display("pin test done");
        rst_b <= 0;
        repeat (2) @(posedge clock);
        rst_b <= 1;
        @(posedge clock);
        for (int i = 0; i < 3; i++)
            chk(8'h21 + i[7:0], 8'h00);
        `CHK({pinSixteenOe, pinSixteenOut}, 2'h2)
        $display("second reset test done");
        endOfTest;
    end
endmodule // tb_top
`default_nettype wire
